// ==== rtl/accum_clear_ctrl.sv ====
// Purpose: control bits 16..10 of control_function_one, apb slave
// Assumes: apb master holds requests until pready; 100 MHz clk_i
// Notes:   effects are aligned to the divided core clock enable
//          events between the same two core ticks merge into a single update
//          the status word shows the active copy of control_function_one
`timescale 1ns/10ps
`include "accum_clear_cfg.svh"

// Operation
// - bit 16 picks sine (one, default) or cosine (zero) output
// - bit 15 does nothing unless ramp enable is set
// - bit 15 set: load new ramp rate on every update event
// - bit 14 set: ramp accumulator reset for exactly one core cycle
// - bit 14 held: repeat that one-cycle reset on each update event
// - bits 14, 12, 11 take effect after an update event, next core edge
// - bit 13 set: phase accumulator reset on each update event
// - bit 12 set: ramp accumulator held in reset while set
// - bit 11 set: phase accumulator held in reset while set
// - written bits reach destinations only after an update event
// - ramp enable bit 19 of control_function_two turns ramp on
module accum_clear_ctrl #(
    parameter int DIV = `SYNC_DIV,
    parameter int PW  = 3
) (
    input  wire logic                      clk_i,
    input  wire logic                      rst_n_i,
    input  wire logic                      psel_i,
    input  wire logic                      penable_i,
    input  wire logic                      pwrite_i,
    input  wire logic [11:0]               paddr_i,
    input  wire logic [31:0]               pwdata_i,
    output logic      [31:0]               prdata_o,
    output logic                           pready_o,
    output logic                           pslverr_o,
    input  wire logic                      update_i,
    input  wire logic [PW-1:0]             profile_select_pins_i,
    output accum_clear_pkg::core_ctrl_t    core_ctrl_o,
    output logic                           core_tick_o
);
    ////////////////////////////////////////////////////////////////////////
    logic [31:0] control_function_one_reg;
    logic [31:0] control_function_two_reg;
    logic [31:0] active_one_reg;
    logic [31:0] active_two_reg;
    logic [$clog2(DIV)-1:0] div_reg;
    logic        tick;
    logic        event_raw;
    logic        pending_reg;
    logic        apply;
    logic        ramp_reset_reg;
    logic        load_pulse_reg;
    logic        phase_reset_reg;
    logic        wr_en;

    // reset image of word one, so single reset bits can be picked by name
    localparam logic [31:0] ONE_RESET = `CF1_RESET;

    // address compare, shared by the write, read and error decode
    function automatic logic hit(input logic [11:0] a, input logic [11:0] off);
        hit = (a == off);
    endfunction

    // list of mapped offsets for the error decode; the write and read decodes name them too
    function automatic logic mapped(input logic [11:0] a);
        mapped = hit(a, `CF1_OFFSET) || hit(a, `CF2_OFFSET) || hit(a, `STATUS_OFFSET);
    endfunction

    // read decode; unmapped addresses read as zero
    function automatic logic [31:0] read_word(input logic [11:0] a,
                                              input logic [31:0] one,
                                              input logic [31:0] two,
                                              input logic [31:0] act);
        if (hit(a, `CF1_OFFSET)) begin
            read_word = one;
        end else if (hit(a, `CF2_OFFSET)) begin
            read_word = two;
        end else if (hit(a, `STATUS_OFFSET)) begin
            read_word = act;
        end else begin
            read_word = '0;
        end
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // apb: zero wait states, unmapped addresses raise pslverr
    // pready is tied high, so every access phase is a single cycle
    assign pready_o  = 1'b1;
    assign wr_en     = psel_i && penable_i && pwrite_i;
    assign pslverr_o = psel_i && penable_i && !mapped(paddr_i);

    // shadow copy one; the reserved bit is masked so it always reads zero
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            control_function_one_reg <= `CF1_RESET;
        end else if (wr_en && hit(paddr_i, `CF1_OFFSET)) begin
            control_function_one_reg <= pwdata_i & `CF1_WR_MASK;
        end
    end

    // shadow copy two; only the ramp enable bit matters to this block
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            control_function_two_reg <= `CF2_RESET;
        end else if (wr_en && hit(paddr_i, `CF2_OFFSET)) begin
            control_function_two_reg <= pwdata_i;
        end
    end

    // read data registered in the setup cycle, so it stands through the access phase
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            prdata_o <= '0;
        end else if (psel_i && !penable_i && !pwrite_i) begin
            prdata_o <= read_word(paddr_i, control_function_one_reg,
                                  control_function_two_reg, active_one_reg);
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // core clock enable divider; stands in for the synthesizer sync clock
    // it runs freely from reset, so an update may land anywhere in a core period
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            div_reg <= '0;
        end else if (div_reg == ($clog2(DIV))'(DIV - 1)) begin
            div_reg <= '0;
        end else begin
            div_reg <= div_reg + 1'b1;
        end
    end
    assign tick        = (div_reg == ($clog2(DIV))'(DIV - 1));
    assign core_tick_o = tick;

    // pins are asynchronous; the detector carries the synchroniser stages
    update_event_detect #(.PW(PW)) u_detect (
        .clk_i                 (clk_i),
        .rst_n_i               (rst_n_i),
        .update_i              (update_i),
        .profile_select_pins_i (profile_select_pins_i),
        .event_o               (event_raw)
    );

    // an event between ticks waits for the next core edge; an event that meets a
    // tick is used by that tick at once, so it is not left pending to apply twice
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            pending_reg <= 1'b0;
        end else if (tick) begin
            pending_reg <= 1'b0;
        end else if (event_raw) begin
            pending_reg <= 1'b1;
        end
    end
    assign apply = tick && (pending_reg || event_raw);

    // active copy one: taken from the shadow only on an applied update
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            active_one_reg <= `CF1_RESET;
        end else if (apply) begin
            active_one_reg <= control_function_one_reg;
        end
    end

    // active copy two: same gate, so the ramp enable moves with the clear bits
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            active_two_reg <= `CF2_RESET;
        end else if (apply) begin
            active_two_reg <= control_function_two_reg;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // ramp accumulator reset: an autoclear pulse of one core cycle from the newly
    // applied bits, or the static clear while the active bit is set; kept in a
    // flop so the core never sees a glitch where the pulse meets the static level
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            ramp_reset_reg <= ONE_RESET[`CF1_RAMP_CLR_BIT];
        end else if (apply) begin
            ramp_reset_reg <= control_function_one_reg[`CF1_RAMP_AUTO_BIT] ||
                              control_function_one_reg[`CF1_RAMP_CLR_BIT];
        end else if (tick) begin
            ramp_reset_reg <= active_one_reg[`CF1_RAMP_CLR_BIT];
        end
    end

    // phase accumulator reset: autoclear on each applied update, or static clear;
    // it changes only on core edges, like the accumulator it resets
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            phase_reset_reg <= ONE_RESET[`CF1_PHASE_CLR_BIT];
        end else if (apply) begin
            phase_reset_reg <= control_function_one_reg[`CF1_PHASE_AUTO_BIT] ||
                               control_function_one_reg[`CF1_PHASE_CLR_BIT];
        end else if (tick) begin
            phase_reset_reg <= active_one_reg[`CF1_PHASE_CLR_BIT];
        end
    end

    // rate reload: one core cycle, and only with ramp enable in the same update,
    // so a reload never reaches a ramp generator that is switched off
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            load_pulse_reg <= 1'b0;
        end else if (tick) begin
            load_pulse_reg <= apply &&
                              control_function_one_reg[`CF1_LOAD_RATE_BIT] &&
                              control_function_two_reg[`CF2_RAMP_EN_BIT];
        end
    end

    // outputs to the synthesizer core; every field is a flop bit
    always_comb begin
        core_ctrl_o.sine_select     = active_one_reg[`CF1_SINE_BIT];
        core_ctrl_o.load_rate_pulse = load_pulse_reg;
        core_ctrl_o.ramp_acc_reset  = ramp_reset_reg;
        core_ctrl_o.phase_acc_reset = phase_reset_reg;
        core_ctrl_o.ramp_enable     = active_two_reg[`CF2_RAMP_EN_BIT];
    end
endmodule

// ==== rtl/accum_clear_cfg.svh ====
// Purpose: named constants for the accumulator clear control block
// Assumes: 32-bit apb data, one aligned word per register
// Notes:   offsets are byte addresses
`ifndef ACCUM_CLEAR_CFG_SVH
`define ACCUM_CLEAR_CFG_SVH
`define CF1_OFFSET        12'h000
`define CF2_OFFSET        12'h004
`define STATUS_OFFSET     12'h008
`define CF1_SINE_BIT      16
`define CF1_LOAD_RATE_BIT 15
`define CF1_RAMP_AUTO_BIT 14
`define CF1_PHASE_AUTO_BIT 13
`define CF1_RAMP_CLR_BIT  12
`define CF1_PHASE_CLR_BIT 11
`define CF1_RSVD_BIT      10
`define CF2_RAMP_EN_BIT   19
`define CF1_RESET         32'h0001_0000
`define CF2_RESET         32'h0000_0000
`define CF1_WR_MASK       32'hffff_fbff
`define SYNC_DIV          4
`endif

// ==== rtl/accum_clear_pkg.sv ====
// Purpose: shared types for the accumulator clear control block
// Assumes: constants live in accum_clear_cfg.svh
// Notes:   controls travel as one packed struct
package accum_clear_pkg;
    // effective controls as seen by the synthesizer core
    typedef struct packed {
        logic sine_select;
        logic load_rate_pulse;
        logic ramp_acc_reset;
        logic phase_acc_reset;
        logic ramp_enable;
    } core_ctrl_t;
endpackage

// ==== rtl/update_event_detect.sv ====
// Purpose: synchronise update strobe and profile pins, flag one event
// Assumes: pins are asynchronous to clk_i
// Notes:   three flops; a change counts when stages two and three agree
`timescale 1ns/10ps
module update_event_detect #(
    parameter int PW = 3
) (
    input  wire logic          clk_i,
    input  wire logic          rst_n_i,
    input  wire logic          update_i,
    input  wire logic [PW-1:0] profile_select_pins_i,
    output logic               event_o
);
    logic [PW:0] s1_reg;
    logic [PW:0] s2_reg;
    logic [PW:0] s3_reg;
    logic [PW:0] stable_reg;

    // first stage is read only by the second
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            s1_reg <= '0;
            s2_reg <= '0;
            s3_reg <= '0;
        end else begin
            s1_reg <= {update_i, profile_select_pins_i};
            s2_reg <= s1_reg;
            s3_reg <= s2_reg;
        end
    end

    // accepted value moves only when stages two and three agree
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            stable_reg <= '0;
        end else if (s2_reg == s3_reg) begin
            stable_reg <= s3_reg;
        end
    end

    // rising update or any profile change is one event
    assign event_o = (s2_reg == s3_reg) &&
                     ((s3_reg[PW] && !stable_reg[PW]) ||
                      (s3_reg[PW-1:0] != stable_reg[PW-1:0]));
endmodule

// ==== test/accum_clear_chk.sv ====
// Purpose: port assertions for accum_clear_ctrl
// Assumes: DIV of 4, zero-wait apb slave
// Notes:   every change of core_ctrl_o rides on core_tick_o
`timescale 1ns/10ps
module accum_clear_chk #(
    parameter int DIV = 4
) (
    input wire logic                        clk_i,
    input wire logic                        rst_n_i,
    input wire logic                        psel_i,
    input wire logic                        penable_i,
    input wire logic                        pwrite_i,
    input wire logic [11:0]                 paddr_i,
    input wire logic [31:0]                 prdata_o,
    input wire logic                        pslverr_o,
    input wire accum_clear_pkg::core_ctrl_t core_ctrl_o,
    input wire logic                        core_tick_o
);
    // short aliases keep the properties on one line
    wire ld = core_ctrl_o.load_rate_pulse;
    wire rr = core_ctrl_o.ramp_acc_reset;
    wire pr = core_ctrl_o.phase_acc_reset;
    wire ap = psel_i && penable_i;
    default clocking @(posedge clk_i); endclocking
    default disable iff (!rst_n_i);
    property p_tick; core_tick_o |=> !core_tick_o [*3] ##1 core_tick_o; endproperty
    a_tick: assert property (p_tick) else $error("core tick spacing");
    property p_chg; $changed(core_ctrl_o) |-> $past(core_tick_o); endproperty
    a_chg: assert property (p_chg) else $error("control moved off tick");
    property p_gate; ld |-> core_ctrl_o.ramp_enable; endproperty
    a_gate: assert property (p_gate) else $error("load without ramp enable");
    property p_ld; $rose(ld) |-> ld [*4]; endproperty
    a_ld: assert property (p_ld) else $error("load pulse short");
    property p_rr; $rose(rr) |-> rr [*4]; endproperty
    a_rr: assert property (p_rr) else $error("ramp reset short");
    property p_pr; $rose(pr) |-> pr [*4]; endproperty
    a_pr: assert property (p_pr) else $error("phase reset short");
    property p_err; ap |-> pslverr_o == !(paddr_i inside {12'h000, 12'h004, 12'h008}); endproperty
    a_err: assert property (p_err) else $error("bad slave error");
    property p_rsv; ap && !pwrite_i && paddr_i inside {12'h000, 12'h008} |-> !prdata_o[10]; endproperty
    a_rsv: assert property (p_rsv) else $error("reserved bit read one");
    // main scenarios
    c_ld: cover property ($rose(ld));
    c_rr: cover property ($rose(rr));
    c_err: cover property (ap && pslverr_o);
endmodule
bind accum_clear_ctrl accum_clear_chk #(.DIV(DIV)) u_accum_clear_chk (
    .clk_i, .rst_n_i, .psel_i, .penable_i, .pwrite_i, .paddr_i,
    .prdata_o, .pslverr_o, .core_ctrl_o, .core_tick_o);

// ==== test/host_pins_model.sv ====
// Purpose: host side of the update strobe and profile pins
// Assumes: driven just after clk_i rising edges
// Notes:   strobe held two cycles so the synchroniser sees it
`timescale 1ns/10ps
module host_pins_model (
    input  wire logic       clk_i,
    output logic            update_o,
    output logic [2:0]      profile_o
);
    // pins idle until the bench asks for an event
    initial begin
        update_o = 1'h0;
        profile_o = 3'h0;
    end
    // only the rising edge counts, so drop back low afterwards
    task automatic strobe();
        @(posedge clk_i) update_o <= 1'h1;
        repeat (2) @(posedge clk_i);
        update_o <= 1'h0;
    endtask
    // any change of the profile pins is one event
    task automatic step();
        @(posedge clk_i) profile_o <= profile_o + 3'h1;
    endtask
endmodule

// ==== test/accum_clear_ctrl_tb.sv ====
// Purpose: self-checking bench for accum_clear_ctrl
// Assumes: DIV of 4, zero-wait apb slave
// Notes:   pulse widths are counted over a window after each event
`timescale 1ns/10ps
`include "accum_clear_cfg.svh"
`define CHK(a, e) begin checks_done++; if ((a) !== (e)) begin error_cnt++; \
    $display("mismatch at %0t: got %h want %h", $time, a, e); end end
module accum_clear_ctrl_tb;
    logic        clk_i, rst_n_i, psel_i, penable_i, pwrite_i, update_i, re;
    logic        pready_o, pslverr_o, core_tick_o;
    logic [11:0] paddr_i;
    logic [31:0] pwdata_i, prdata_o, rq;
    logic [2:0]  prof;
    int          error_cnt, checks_done, nr, np, nl;
    accum_clear_pkg::core_ctrl_t core_ctrl_o;
    accum_clear_ctrl u_accum_clear_ctrl (.clk_i, .rst_n_i, .psel_i, .penable_i,
        .pwrite_i, .paddr_i, .pwdata_i, .prdata_o, .pready_o, .pslverr_o, .update_i,
        .profile_select_pins_i(prof), .core_ctrl_o, .core_tick_o);
    host_pins_model u_host_pins_model (.clk_i, .update_o(update_i), .profile_o(prof));
    ////////////////////////////////////////////////////////////////
    task automatic conclude();
        $display("checks %0d mismatches %0d", checks_done, error_cnt);
        if (error_cnt == 0 && checks_done > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    // one apb transfer; data and error taken at the pready edge
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int n;
        @(posedge clk_i);
        {psel_i, penable_i, pwrite_i, paddr_i, pwdata_i} <= {1'h1, 1'h0, w, a, d};
        @(posedge clk_i) penable_i <= 1'h1;
        for (n = 0; n < 8; n++) begin
            @(posedge clk_i);
            if (pready_o === 1'h1) break;
        end
        rq = prdata_o;
        re = pslverr_o;
        {psel_i, penable_i} <= 2'h0;
        if (n == 8) begin
            error_cnt++;
            conclude();
        end
    endtask
    // raise one event and count pulse cycles over a fixed window
    task automatic fire(input logic by_profile);
        if (by_profile) u_host_pins_model.step();
        else u_host_pins_model.strobe();
        {nr, np, nl} = '0;
        repeat (20) begin
            @(posedge clk_i);
            if (core_ctrl_o.ramp_acc_reset === 1'h1) nr++;
            if (core_ctrl_o.phase_acc_reset === 1'h1) np++;
            if (core_ctrl_o.load_rate_pulse === 1'h1) nl++;
        end
    endtask
    initial begin
        clk_i = 1'h0;
        forever #5 clk_i = ~clk_i;
    end
    ////////////////////////////////////////////////////////////////
    initial begin
        {rst_n_i, psel_i, penable_i, pwrite_i, paddr_i, pwdata_i} = '0;
        repeat (12) @(posedge clk_i);
        rst_n_i <= 1'h1;
        apb(1'h0, `CF1_OFFSET, 32'h0);
        `CHK(rq, `CF1_RESET)
        `CHK(core_ctrl_o, 5'h10)
        apb(1'h0, `CF2_OFFSET, 32'h0);
        `CHK(rq, `CF2_RESET)
        $display("reset values done");
        apb(1'h1, `CF1_OFFSET, 32'h0001_6000);
        fire(1'h1);
        `CHK({nr, np, nl}, {32'd4, 32'd4, 32'd0})
        fire(1'h0);
        `CHK({nr, np}, {32'd4, 32'd4})
        $display("autoclear done");
        apb(1'h1, `CF1_OFFSET, 32'h0001_8000);
        fire(1'h0);
        `CHK({nr, nl}, {32'd0, 32'd0})
        apb(1'h1, `CF2_OFFSET, 32'h0008_0000);
        fire(1'h1);
        `CHK(nl, 4)
        `CHK(core_ctrl_o, 5'h11)
        $display("rate load done");
        apb(1'h1, `CF1_OFFSET, 32'h0000_1c00);
        apb(1'h0, `CF1_OFFSET, 32'h0);
        `CHK(rq, 32'h0000_1800)
        `CHK(core_ctrl_o, 5'h11)
        fire(1'h0);
        `CHK(core_ctrl_o, 5'h07)
        apb(1'h0, `STATUS_OFFSET, 32'h0);
        `CHK(rq, 32'h0000_1800)
        $display("static clear done");
        apb(1'h0, 12'h00c, 32'h0);
        `CHK({re, rq}, {1'h1, 32'h0})
        $display("unmapped done");
        conclude();
    end
endmodule
